// ===== apsr_pkg.sv
/*
 * Types for the arbitrary pulse segment register bank.
 * Assumes apsr_regs.svh is on the include path.
 */
`default_nettype none
`include "apsr_regs.svh"

package apsr_pkg;

   typedef logic [`APSR_LEVEL_MSB:0] apsr_level_t;
   typedef logic [`APSR_SEG_REG_W-1:0] apsr_byte_t;

   typedef struct packed {
      apsr_level_t segment_one_level;
      apsr_level_t segment_two_level;
      apsr_level_t segment_three_level;
      apsr_level_t segment_four_level;
      apsr_level_t segment_five_level;
   } apsr_levels_s;

   typedef struct packed {
      logic active;
      logic [2:0] segment;
      apsr_level_t amplitude;
      logic signed [7:0] twos;
   } apsr_pulse_s;

   typedef enum logic {
      APSR_IDLE,
      APSR_RUN
   } apsr_state_e;

endpackage : apsr_pkg

`default_nettype wire

// ===== apsr_properties.sv
/* port checker for apsr_top.
   assumes a bind onto apsr_top; one clock, async low reset. */
`timescale 1ns/10ps
`default_nettype none
module apsr_props
   import apsr_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter logic [4:0] ARB_EQ_CODE = 5'h1f
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pulse_start,
   input wire apsr_levels_s segment_levels,
   input wire logic arb_mode,
   input wire apsr_pulse_s pulse
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic [11:0] ix = paddr[13:2];
   wire logic acc = psel && penable;
   wire logic wr = acc && pwrite && pstrb[0];
   chk_amp_off: assert property (!$past(arb_mode) |->
      pulse.amplitude == 7'h00) else $error("amplitude outside arb mode");
   chk_slot_one: assert property (pulse.active && pulse.segment == 3'h0
      && $past(arb_mode) |-> pulse.amplitude ==
      $past(segment_levels.segment_one_level)) else $error("slot one level");
   chk_late_slots: assert property (pulse.active && pulse.segment > 3'h4
      |-> pulse.amplitude == 7'h00) else $error("late slot not zero");
   chk_twos_conv: assert property (pulse.twos == (pulse.amplitude[6] ?
      -$signed({2'b00, pulse.amplitude[5:0]}) :
      $signed({2'b00, pulse.amplitude[5:0]}))) else $error("twos wrong");
   chk_start_lat: assert property ($rose(pulse.active) |->
      $past(pulse_start, 2)) else $error("pulse without start");
   chk_seg_write: assert property (wr && ix == 12'hf09 |=>
      segment_levels.segment_two_level == $past(pwdata[6:0]))
      else $error("segment two not written");
   chk_bad_addr: assert property (acc && !(ix inside {[12'hf09:12'hf0d],
      12'hf00, 12'hf10}) |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped not refused");
   chk_upper_zero: assert property (acc && !pwrite |->
      prdata[31:8] == 24'h0) else $error("upper read bits set");
   chk_arb_decode: assert property (wr && ix == 12'hf00 |=>
      arb_mode == ($past(pwdata[4:0]) == ARB_EQ_CODE)) else $error("arb decode");
   cover property ($rose(pulse.active) && arb_mode);
   cover property (pslverr);
   cover property (wr && ix == 12'hf0d);
endmodule : apsr_props
bind apsr_top apsr_props #(.ADDR_W(ADDR_W), .ARB_EQ_CODE(ARB_EQ_CODE))
   u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pulse_start(pulse_start), .segment_levels(segment_levels),
   .arb_mode(arb_mode), .pulse(pulse));
`default_nettype wire

// ===== apsr_regs.svh
/*
 * Register indices, field positions, reset values and timing defaults for
 * the arbitrary pulse segment register bank.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef APSR_REGS_SVH
`define APSR_REGS_SVH

// register indices; byte address is four times the index
`define APSR_IDX_SEG_ONE 12'hf0d
`define APSR_IDX_SEG_TWO 12'hf09
`define APSR_IDX_SEG_THREE 12'hf0a
`define APSR_IDX_SEG_FOUR 12'hf0b
`define APSR_IDX_SEG_FIVE 12'hf0c
`define APSR_IDX_EQ_CTRL 12'hf00
`define APSR_IDX_STATUS 12'hf10

// word offset bits below the index, and the index width
`define APSR_IDX_LSB 2
`define APSR_IDX_W 12

// segment register layout
`define APSR_SEG_REG_W 8
`define APSR_SEG_RESET 8'h00
`define APSR_LEVEL_MSB 6
`define APSR_SIGN_BIT 6
`define APSR_RSVD_BIT 7

// equalizer control layout
`define APSR_EQ_MSB 4
`define APSR_EQ_RESET 5'h00
`define APSR_ARB_EQ_CODE_DEF 5'h1f

// status layout
`define APSR_STAT_SEG_MSB 2
`define APSR_STAT_ACTIVE_BIT 3

// pulse shape geometry and slot timing
`define APSR_NUM_REGS 5
`define APSR_NUM_SLOTS 8
`define APSR_LAST_SLOT 3'h7
`define APSR_SLOT_CYCLES_DEF 4

`endif

// ===== apsr_top.sv
/*
 * Arbitrary pulse segment register bank with an APB slave and a
 * segment sequencer driving the transmit pulse shaper amplitude.
 * Assumes an APB master on pclk and a pulse start strobe synchronous
 * to pclk; segments six to eight lie outside this block and read as zero.
 */
// Register access over APB was left to the implementer.
//
// Overview of operation
// - each segment byte has a read/write 7-bit amplitude field, reset zero
// - amplitude is signed magnitude: bit 6 sign, bit 0 magnitude lsb
// - five registers feed segments one to five of an eight-slot pulse
// - amplitudes reach the pulse only while equalizer selects arbitrary mode
// - each stored value drives its segment's time slice of the pulse
`timescale 1ns/10ps
`default_nettype none
`include "apsr_regs.svh"

module apsr_top
   import apsr_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter int SLOT_CYCLES = `APSR_SLOT_CYCLES_DEF,
   parameter logic [`APSR_EQ_MSB:0] ARB_EQ_CODE = `APSR_ARB_EQ_CODE_DEF
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pulse_start,
   output apsr_levels_s segment_levels,
   output logic arb_mode,
   output apsr_pulse_s pulse
);

   localparam int CNT_W = (SLOT_CYCLES > 1) ? $clog2(SLOT_CYCLES) : 1;
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SLOT_CYCLES - 1);

   localparam logic [`APSR_IDX_W-1:0] SEG_IDX [`APSR_NUM_REGS] = '{
      `APSR_IDX_SEG_ONE,
      `APSR_IDX_SEG_TWO,
      `APSR_IDX_SEG_THREE,
      `APSR_IDX_SEG_FOUR,
      `APSR_IDX_SEG_FIVE
   };

   // elaboration checks on parameters the logic cannot serve
   if (ADDR_W < `APSR_IDX_W + `APSR_IDX_LSB)
   begin : g_addr_chk
      $error("apsr_top: ADDR_W too narrow for register map");
   end
   if (SLOT_CYCLES < 1)
   begin : g_slot_chk
      $error("apsr_top: SLOT_CYCLES must be at least one");
   end

   apsr_byte_t seg_q [`APSR_NUM_REGS];
   logic [`APSR_EQ_MSB:0] eq_sel_q;
   apsr_state_e state_q;
   logic [2:0] slot_q;
   logic [CNT_W-1:0] cnt_q;
   logic [31:0] prdata_q;
   apsr_pulse_s pulse_q;

   logic [`APSR_IDX_W-1:0] idx;
   logic [`APSR_NUM_REGS-1:0] seg_hit;
   logic eq_hit;
   logic stat_hit;
   logic any_hit;
   logic wr_en;
   logic slot_tick;
   logic [`APSR_STAT_ACTIVE_BIT:0] status;
   apsr_level_t slot_level;

   assign idx = paddr[`APSR_IDX_LSB +: `APSR_IDX_W];
   assign eq_hit = (idx == `APSR_IDX_EQ_CTRL);
   assign stat_hit = (idx == `APSR_IDX_STATUS);
   assign any_hit = (|seg_hit) | eq_hit | stat_hit;
   assign wr_en = psel & penable & pwrite & pstrb[0];

   // zero wait states; unmapped reads and writes, and writes to read-only status, answer with error
   assign pready = 1'b1;
   assign pslverr = psel & penable & (~any_hit | (pwrite & stat_hit));
   assign prdata = prdata_q;

   // per-segment decode and storage, bit 7 kept as plain storage
   genvar g;
   generate
      for (g = 0; g < `APSR_NUM_REGS; g++)
      begin : g_seg
         assign seg_hit[g] = (idx == SEG_IDX[g]);
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               seg_q[g] <= `APSR_SEG_RESET;
            else if (wr_en && seg_hit[g])
               seg_q[g] <= pwdata[`APSR_SEG_REG_W-1:0];
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         eq_sel_q <= `APSR_EQ_RESET;
      else if (wr_en && eq_hit)
         eq_sel_q <= pwdata[`APSR_EQ_MSB:0];
   end

   assign status = {state_q == APSR_RUN, slot_q};

   // read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_q <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         prdata_q <= 32'h0000_0000;
         if (seg_hit[0])
            prdata_q[`APSR_SEG_REG_W-1:0] <= seg_q[0];
         else if (seg_hit[1])
            prdata_q[`APSR_SEG_REG_W-1:0] <= seg_q[1];
         else if (seg_hit[2])
            prdata_q[`APSR_SEG_REG_W-1:0] <= seg_q[2];
         else if (seg_hit[3])
            prdata_q[`APSR_SEG_REG_W-1:0] <= seg_q[3];
         else if (seg_hit[4])
            prdata_q[`APSR_SEG_REG_W-1:0] <= seg_q[4];
         else if (eq_hit)
            prdata_q[`APSR_EQ_MSB:0] <= eq_sel_q;
         else if (stat_hit)
            prdata_q[`APSR_STAT_ACTIVE_BIT:0] <= status;
      end
   end

   assign arb_mode = (eq_sel_q == ARB_EQ_CODE);

   // levels handed to the shaper, reserved bit dropped
   assign segment_levels.segment_one_level = seg_q[0][`APSR_LEVEL_MSB:0];
   assign segment_levels.segment_two_level = seg_q[1][`APSR_LEVEL_MSB:0];
   assign segment_levels.segment_three_level = seg_q[2][`APSR_LEVEL_MSB:0];
   assign segment_levels.segment_four_level = seg_q[3][`APSR_LEVEL_MSB:0];
   assign segment_levels.segment_five_level = seg_q[4][`APSR_LEVEL_MSB:0];

   // slot divider enable
   assign slot_tick = (state_q == APSR_RUN) && (cnt_q == CNT_LAST);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_q <= '0;
      else if (state_q != APSR_RUN || cnt_q == CNT_LAST)
         cnt_q <= '0;
      else
         cnt_q <= cnt_q + CNT_W'(1);
   end

   // slot sequencer across eight time slices
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= APSR_IDLE;
         slot_q <= 3'h0;
      end
      else
      begin
         case (state_q)
            APSR_IDLE:
            begin
               slot_q <= 3'h0;
               if (pulse_start)
                  state_q <= APSR_RUN;
            end
            APSR_RUN:
            begin
               if (slot_tick)
               begin
                  if (slot_q == `APSR_LAST_SLOT)
                  begin
                     state_q <= APSR_IDLE;
                     slot_q <= 3'h0;
                  end
                  else
                     slot_q <= slot_q + 3'h1;
               end
            end
            default:
               state_q <= APSR_IDLE;
         endcase
      end
   end

   // level of the current slice, zero outside arbitrary mode
   always_comb
   begin
      slot_level = '0;
      if (arb_mode && state_q == APSR_RUN)
      begin
         if (slot_q < 3'(`APSR_NUM_REGS))
            slot_level = seg_q[slot_q][`APSR_LEVEL_MSB:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pulse_q <= '0;
      else
      begin
         pulse_q.active <= (state_q == APSR_RUN);
         pulse_q.segment <= slot_q;
         pulse_q.amplitude <= slot_level;
         if (slot_level[`APSR_SIGN_BIT])
            pulse_q.twos <= -$signed({2'b00, slot_level[`APSR_SIGN_BIT-1:0]});
         else
            pulse_q.twos <= $signed({2'b00, slot_level[`APSR_SIGN_BIT-1:0]});
      end
   end

   assign pulse = pulse_q;

endmodule : apsr_top

`default_nettype wire

// ===== tb_apsr_top.sv
/* self-checking bench for apsr_top over apb.
   assumes default parameters: 4 cycles a slot, arb code 5'h1f. */
`timescale 1ns/10ps
`default_nettype none
`include "apsr_regs.svh"
module tb_apsr_top;
   import apsr_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr, er, pulse_start = 0, arb_mode;
   apsr_levels_s segment_levels;
   apsr_pulse_s pulse;
   int bad_count = 0, n_checks = 0;
   logic [11:0] ix [5] = '{12'hf0d, 12'hf09, 12'hf0a, 12'hf0b, 12'hf0c};
   logic [7:0] v [5] = '{8'hc5, 8'h3f, 8'h41, 8'h7f, 8'h80};
   apsr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pulse_start(pulse_start), .segment_levels(segment_levels),
      .arb_mode(arb_mode), .pulse(pulse));
   initial forever #4 pclk = ~pclk;
   task finish_test;
      if (bad_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   task cmp(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp
   task apb(input logic w, input logic [11:0] i, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= {2'b00, i, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 0; penable <= 0;
      if (k >= 20)
      begin
         bad_count++;
         finish_test();
      end
   endtask : apb
   task t_reset;
      for (int i = 0; i < 5; i++)
      begin
         apb(0, ix[i], 32'h0);
         cmp(rd, 32'h0);
      end
   endtask : t_reset
   task t_err;
      apb(0, 12'h0ff, 32'h0);
      cmp({31'h0, er}, 32'h1);
      cmp(rd, 32'h0);
      apb(1, `APSR_IDX_STATUS, 32'hf);
      cmp({31'h0, er}, 32'h1);
      apb(0, `APSR_IDX_STATUS, 32'h0);
      cmp(rd, 32'h0);
      cmp({31'h0, er}, 32'h0);
   endtask : t_err
   task t_rw;
      for (int i = 0; i < 5; i++)
      begin
         apb(1, ix[i], {24'hffffff, v[i]});
         pstrb <= 4'he;
         apb(1, ix[i], 32'h0);
         pstrb <= 4'hf;
         apb(0, ix[i], 32'h0);
         cmp(rd, {24'h0, v[i]});
      end
      for (int i = 0; i < 5; i++)
         cmp({25'h0, segment_levels[34-7*i -: 7]}, {25'h0, v[i][6:0]});
   endtask : t_rw
   task t_pulse(input logic arb);
      logic [6:0] a;
      int k;
      apb(1, `APSR_IDX_EQ_CTRL, arb ? 32'h1f : 32'h0);
      pulse_start <= 1;
      @(posedge pclk);
      pulse_start <= 0;
      for (k = 0; k < 10 && pulse.active !== 1'b1; k++)
         @(posedge pclk) #1;
      if (pulse.active !== 1'b1)
      begin
         bad_count++;
         finish_test();
      end
      cmp({31'h0, arb_mode}, {31'h0, arb});
      for (int s = 0; s < 8; s++)
      begin
         a = (arb && s < 5) ? v[s][6:0] : 7'h00;
         cmp({29'h0, pulse.segment}, s);
         cmp({25'h0, pulse.amplitude}, {25'h0, a});
         cmp({24'h0, pulse.twos}, {24'h0, a[6] ? 8'h0 - {2'b00, a[5:0]}
            : {2'b00, a[5:0]}});
         repeat (4) @(posedge pclk);
         #1;
      end
      cmp({31'h0, pulse.active}, 32'h0);
   endtask : t_pulse
   task t_midreset;
      @(posedge pclk);
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      t_reset();
      cmp({31'h0, arb_mode}, 32'h0);
   endtask : t_midreset
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      t_reset();
      t_err();
      t_rw();
      t_pulse(0);
      t_pulse(1);
      t_midreset();
      finish_test();
   end
endmodule : tb_apsr_top
`default_nettype wire
